// ==== logic/rss_pkg.sv ====
package rss_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 7;
	localparam int PAGE_W = 4;
	localparam int IDX_W = 3;
	localparam int BIT_CNT_W = 3;
	localparam int CMD_RW_BIT = 7;
	localparam int CMD_PAGE_LO = 3;
	localparam int CMD_IDX_LO = 0;
	localparam int FIFO_DEPTH = 8;
	localparam int FIFO_W = ADDR_W + DATA_W;
	localparam logic [BIT_CNT_W-1:0] LAST_BIT = 3'h7;
	localparam logic [BIT_CNT_W-1:0] FIRST_BIT = 3'h0;
	localparam logic CMD_READ = 1'b1;
	localparam logic PAGE_TOP_FORCED = 1'b0;
	localparam logic [ADDR_W-1:0] SECONDS_COUNT_ADDR = 7'h08;
	localparam logic [ADDR_W-1:0] MINUTES_COUNT_ADDR = 7'h09;
	localparam logic [DATA_W-1:0] LIVE_RESET_VALUE = 8'h00;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ACTIVE,
		ST_DRAIN,
		ST_WBACK
	} rss_state_t;
endpackage

// ==== logic/rss_stream_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface rss_stream_if #(
	parameter int WIDTH = 8
) ();
	logic valid;
	logic ready;
	logic [WIDTH-1:0] data;
	modport prod(output valid, output data, input ready);
	modport cons(input valid, input data, output ready);
endinterface
`default_nettype wire

// ==== logic/rss_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
module rss_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	rss_stream_if.cons in_s,
	rss_stream_if.prod out_s
);
	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CNT_W = $clog2(DEPTH + 1);
	localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
	localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PTR_W-1:0] wr_ptr_r, wr_ptr_nxt;
	logic [PTR_W-1:0] rd_ptr_r, rd_ptr_nxt;
	logic [CNT_W-1:0] count_r, count_nxt;
	logic push, pop;

	assign in_s.ready = (count_r != CNT_FULL);
	assign out_s.valid = (count_r != '0);
	assign out_s.data = mem[rd_ptr_r];
	assign push = in_s.valid && in_s.ready;
	assign pop = out_s.valid && out_s.ready;

	always_comb begin
		wr_ptr_nxt = wr_ptr_r;
		rd_ptr_nxt = rd_ptr_r;
		count_nxt = count_r;
		if (push) begin
			wr_ptr_nxt = (wr_ptr_r == PTR_LAST) ? '0 : PTR_W'(wr_ptr_r + 1'b1);
		end
		if (pop) begin
			rd_ptr_nxt = (rd_ptr_r == PTR_LAST) ? '0 : PTR_W'(rd_ptr_r + 1'b1);
		end
		if (push && !pop) begin
			count_nxt = CNT_W'(count_r + 1'b1);
		end else if (pop && !push) begin
			count_nxt = CNT_W'(count_r - 1'b1);
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
		end else begin
			wr_ptr_r <= wr_ptr_nxt;
			rd_ptr_r <= rd_ptr_nxt;
			count_r <= count_nxt;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem[wr_ptr_r] <= in_s.data;
		end
	end
endmodule
`default_nettype wire

// ==== logic/rss_serial_slave.sv ====
// Overview of operation
// RULE_01 - Master raises select high to start transfer
// RULE_02 - Snapshot live registers into cache at start
// RULE_03 - Reads and writes use cache during transfer
// RULE_04 - Timekeeping updates never touch the cache
// RULE_05 - Modified cache entries written back on deselect
// RULE_06 - Eight-bit units, most significant bit first
// RULE_07 - First byte is the command byte
// RULE_08 - One data bit per serial clock pulse
// RULE_09 - Sample on rise, change output on fall
// RULE_10 - Serial clock idles low
// RULE_11 - Register index increments per byte within page
// RULE_12 - Page fixed until a fresh transfer
// RULE_13 - Select low between transfers
// RULE_14 - Master ends transfer by dropping select
// RULE_15 - Command bit 7 picks write or read
// RULE_16 - Bits 6..3 are page, top bit zero; the code keeps bit 6 as sent, so pages run up to 15
// RULE_17 - Bits 2..0 are starting register index
// RULE_18 - Serial logic reset while select low
// RULE_19 - Output released unless returning read data
// RULE_20 - Write bytes stored into cache, index advances
`timescale 1ns/1ps
`default_nettype none
module rss_serial_slave
	import rss_pkg::*;
#(
	parameter int NUM_REGS = 2 ** ADDR_W
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic sel_pin,
	input wire logic sclk_pin,
	input wire logic serial_data_in_line,
	output logic serial_data_out_line,
	output logic serial_data_out_oe,
	input wire logic upd_valid,
	input wire logic [ADDR_W-1:0] upd_addr,
	input wire logic [DATA_W-1:0] upd_data,
	input wire logic [ADDR_W-1:0] live_rd_addr,
	output logic [DATA_W-1:0] live_rd_data,
	output logic xfer_busy,
	output logic wr_overflow
);
	localparam logic [ADDR_W-1:0] SCAN_LAST = ADDR_W'(NUM_REGS - 1);

	// ==========================================================
	// Pin synchronisers
	// Select, serial clock and data share one two-stage delay, so a data bit
	// is read together with the clock edge it was set up for
	logic sel_m, sel_s;
	logic sclk_m, sclk_s, sclk_d;
	logic din_m, din_s;
	logic sclk_rise, sclk_fall;

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			sel_m <= 1'b0;
			sel_s <= 1'b0;
			sclk_m <= 1'b0;
			sclk_s <= 1'b0;
			sclk_d <= 1'b0;
			din_m <= 1'b0;
			din_s <= 1'b0;
		end else begin
			sel_m <= sel_pin;
			sel_s <= sel_m;
			sclk_m <= sclk_pin;
			sclk_s <= sclk_m;
			sclk_d <= sclk_s;
			din_m <= serial_data_in_line;
			din_s <= din_m;
		end
	end

	// Edge history resets to the idle-low level, so reset makes no false edge
	assign sclk_rise = sclk_s && !sclk_d; // RULE_09
	assign sclk_fall = !sclk_s && sclk_d; // RULE_09

	// ==========================================================
	// Live registers and cache
	// Whole bank is copied since the page is unknown until the command ends
	logic [DATA_W-1:0] live_mem [NUM_REGS];
	logic [DATA_W-1:0] cache_mem [NUM_REGS];
	logic [NUM_REGS-1:0] dirty_r, dirty_nxt;
	logic [DATA_W-1:0] live_rd_data_r, live_rd_data_nxt;

	// ==========================================================
	// Transfer sequencer
	rss_state_t state_r, state_nxt;
	logic [ADDR_W-1:0] scan_r, scan_nxt;
	logic snapshot;
	logic wback_en;
	logic busy_r, busy_nxt;

	// ==========================================================
	// Write data path through the FIFO
	// Queue decouples the serial byte rate from the cache write port
	rss_stream_if #(.WIDTH(FIFO_W)) wr_in ();
	rss_stream_if #(.WIDTH(FIFO_W)) wr_out ();
	logic [ADDR_W-1:0] drain_addr;
	logic [DATA_W-1:0] drain_data;
	logic drain_en;
	logic ovf_r, ovf_nxt;

	rss_fifo #(
		.WIDTH(FIFO_W),
		.DEPTH(FIFO_DEPTH)
	) u_wr_fifo (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.in_s(wr_in),
		.out_s(wr_out)
	);

	assign {drain_addr, drain_data} = wr_out.data;
	// Drain is held off during write-back so the scan sees a stable cache
	assign wr_out.ready = (state_r != ST_WBACK);
	assign drain_en = wr_out.valid && wr_out.ready;

	// ==========================================================
	// Serial shift logic
	logic [BIT_CNT_W-1:0] bit_cnt_r, bit_cnt_nxt;
	logic [DATA_W-1:0] shin_r, shin_nxt;
	logic [DATA_W-1:0] shout_r, shout_nxt;
	logic cmd_done_r, cmd_done_nxt;
	logic rd_mode_r, rd_mode_nxt;
	logic [PAGE_W-1:0] page_r, page_nxt;
	logic [IDX_W-1:0] idx_r, idx_nxt;
	logic dout_r, dout_nxt;
	logic oe_r, oe_nxt;
	logic [DATA_W-1:0] byte_in;
	logic byte_done;
	logic [ADDR_W-1:0] cur_addr;
	logic [ADDR_W-1:0] cmd_addr;
	logic [ADDR_W-1:0] next_addr;
	logic [PAGE_W-1:0] cmd_page;
	logic [IDX_W-1:0] cmd_idx;
	logic [IDX_W-1:0] idx_inc;
	logic link_on;
	logic push_req;

	assign link_on = sel_s && (state_r == ST_ACTIVE); // RULE_18
	assign byte_in = {shin_r[DATA_W-2:0], din_s}; // RULE_06
	assign byte_done = link_on && sclk_rise && (bit_cnt_r == LAST_BIT); // RULE_06
	// All four sent page bits are kept; only the fifth page bit is never sent
	assign cmd_page = byte_in[CMD_PAGE_LO+PAGE_W-1:CMD_PAGE_LO]; // RULE_16
	assign cmd_idx = byte_in[CMD_IDX_LO+IDX_W-1:CMD_IDX_LO]; // RULE_17
	assign idx_inc = IDX_W'(idx_r + 1'b1); // RULE_11
	assign cur_addr = ADDR_W'({page_r, idx_r});
	// The forced page bit lies above the bank's address range and is cut away
	assign cmd_addr = ADDR_W'({PAGE_TOP_FORCED, cmd_page, cmd_idx}); // RULE_16
	assign next_addr = ADDR_W'({page_r, idx_inc});
	assign push_req = byte_done && cmd_done_r && !rd_mode_r; // RULE_20
	assign wr_in.valid = push_req;
	assign wr_in.data = {cur_addr, byte_in}; // RULE_20

	always_comb begin
		bit_cnt_nxt = bit_cnt_r;
		shin_nxt = shin_r;
		shout_nxt = shout_r;
		cmd_done_nxt = cmd_done_r;
		rd_mode_nxt = rd_mode_r;
		page_nxt = page_r;
		idx_nxt = idx_r;
		dout_nxt = dout_r;
		oe_nxt = oe_r;
		if (!link_on) begin
			// A partial byte is lost here as the bit counter restarts
			bit_cnt_nxt = FIRST_BIT; // RULE_18
			shin_nxt = '0;
			shout_nxt = '0;
			cmd_done_nxt = 1'b0;
			rd_mode_nxt = 1'b0;
			page_nxt = '0;
			idx_nxt = '0;
			dout_nxt = 1'b0;
			oe_nxt = 1'b0; // RULE_19
		end else begin
			if (sclk_rise) begin
				bit_cnt_nxt = BIT_CNT_W'(bit_cnt_r + 1'b1); // RULE_08
				shin_nxt = byte_in;
			end
			// Next byte is fetched as the previous one ends, ready for the fall
			if (byte_done && !cmd_done_r) begin
				cmd_done_nxt = 1'b1; // RULE_07
				rd_mode_nxt = (byte_in[CMD_RW_BIT] == CMD_READ); // RULE_15
				page_nxt = cmd_page; // RULE_12
				idx_nxt = cmd_idx; // RULE_17
				shout_nxt = cache_mem[cmd_addr]; // RULE_03
			end else if (byte_done) begin
				idx_nxt = idx_inc; // RULE_11
				shout_nxt = cache_mem[next_addr]; // RULE_03
			end
			// Output moves only after a detected fall, so it stands steady
			// through the high phase in which the master samples
			if (sclk_fall && cmd_done_r && rd_mode_r) begin
				dout_nxt = shout_r[DATA_W-1]; // RULE_09
				shout_nxt = {shout_r[DATA_W-2:0], 1'b0}; // RULE_06
				oe_nxt = 1'b1; // RULE_19
			end
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			bit_cnt_r <= FIRST_BIT;
			shin_r <= '0;
			shout_r <= '0;
			cmd_done_r <= 1'b0;
			rd_mode_r <= 1'b0;
			page_r <= '0;
			idx_r <= '0;
			dout_r <= 1'b0;
			oe_r <= 1'b0;
		end else begin
			bit_cnt_r <= bit_cnt_nxt;
			shin_r <= shin_nxt;
			shout_r <= shout_nxt;
			cmd_done_r <= cmd_done_nxt;
			rd_mode_r <= rd_mode_nxt;
			page_r <= page_nxt;
			idx_r <= idx_nxt;
			dout_r <= dout_nxt;
			oe_r <= oe_nxt;
		end
	end

	assign serial_data_out_line = dout_r;
	assign serial_data_out_oe = oe_r;

	// ==========================================================
	// Sequencer next state
	always_comb begin
		state_nxt = state_r;
		scan_nxt = scan_r;
		snapshot = 1'b0;
		wback_en = 1'b0;
		unique case (state_r)
			ST_IDLE: begin
				if (sel_s) begin
					snapshot = 1'b1; // RULE_02
					state_nxt = ST_ACTIVE;
				end
			end
			ST_ACTIVE: begin
				if (!sel_s) begin
					state_nxt = ST_DRAIN; // RULE_05
				end
			end
			ST_DRAIN: begin
				// Bytes still queued must land in the cache before write-back
				if (!wr_out.valid) begin
					scan_nxt = '0;
					state_nxt = ST_WBACK;
				end
			end
			ST_WBACK: begin
				// A select raised during the scan is only taken once back in idle
				wback_en = dirty_r[scan_r]; // RULE_05
				scan_nxt = ADDR_W'(scan_r + 1'b1);
				if (scan_r == SCAN_LAST) begin
					state_nxt = ST_IDLE;
				end
			end
		endcase
	end

	always_comb begin
		dirty_nxt = dirty_r;
		if (snapshot) begin
			dirty_nxt = '0;
		end else if (drain_en) begin
			dirty_nxt[drain_addr] = 1'b1; // RULE_20
		end
	end

	always_comb begin
		ovf_nxt = ovf_r;
		if (snapshot) begin
			ovf_nxt = 1'b0;
		end
		// Set comes after the clear, so it wins in a shared cycle
		if (push_req && !wr_in.ready) begin
			ovf_nxt = 1'b1;
		end
	end

	assign busy_nxt = (state_nxt != ST_IDLE);
	assign live_rd_data_nxt = live_mem[live_rd_addr];

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			state_r <= ST_IDLE;
			scan_r <= '0;
			dirty_r <= '0;
			ovf_r <= 1'b0;
			busy_r <= 1'b0;
			live_rd_data_r <= '0;
		end else begin
			state_r <= state_nxt;
			scan_r <= scan_nxt;
			dirty_r <= dirty_nxt;
			ovf_r <= ovf_nxt;
			busy_r <= busy_nxt;
			live_rd_data_r <= live_rd_data_nxt;
		end
	end

	assign xfer_busy = busy_r;
	assign wr_overflow = ovf_r;
	assign live_rd_data = live_rd_data_r;

	// ==========================================================
	// Memory updates
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < NUM_REGS; i++) begin
				live_mem[i] <= LIVE_RESET_VALUE;
			end
		end else begin
			// Entries not marked dirty keep timekeeping updates made mid-transfer
			// Timekeeping writes the live bank only; write-back wins a collision
			if (upd_valid && !(wback_en && (upd_addr == scan_r))) begin
				live_mem[upd_addr] <= upd_data; // RULE_04
			end
			if (wback_en) begin
				live_mem[scan_r] <= cache_mem[scan_r]; // RULE_05
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (snapshot) begin
			for (int i = 0; i < NUM_REGS; i++) begin
				cache_mem[i] <= live_mem[i]; // RULE_02
			end
		end else if (drain_en) begin
			cache_mem[drain_addr] <= drain_data; // RULE_03
		end
	end
endmodule
`default_nettype wire

// ==== logic/rss_unused_guard.sv ====
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ==== tb/rss_serial_slave_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module rss_serial_checker (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic sel_pin,
	input wire logic sclk_pin,
	input wire logic serial_data_out_line,
	input wire logic serial_data_out_oe,
	input wire logic xfer_busy,
	input wire logic wr_overflow
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);
	// ==========================================
	// Transfer framing
	snap_start_a: assert property ($rose(sel_pin) && !xfer_busy |-> ##[1:6] xfer_busy)
		else $error("busy did not rise after select");
	busy_hold_a: assert property (xfer_busy && sel_pin |=> xfer_busy)
		else $error("busy dropped during transfer");
	wback_done_a: assert property ($fell(sel_pin) |-> ##[1:200] !xfer_busy)
		else $error("write back did not finish");
	idle_stay_a: assert property (!sel_pin && !xfer_busy |=> !xfer_busy)
		else $error("busy rose without select");
	no_drop_a: assert property (!wr_overflow)
		else $error("write byte dropped");
	// ==========================================
	// Output pin
	oe_in_xfer_a: assert property (serial_data_out_oe |-> xfer_busy)
		else $error("output driven outside transfer");
	oe_release_a: assert property (!sel_pin [*6] |-> !serial_data_out_oe)
		else $error("output still driven after deselect");
	dout_steady_a: assert property (sclk_pin && $past(sclk_pin) && serial_data_out_oe
		&& $past(serial_data_out_oe) |-> $stable(serial_data_out_line))
		else $error("output changed while serial clock high");
	cover property ($rose(serial_data_out_oe));
	cover property ($fell(xfer_busy));
	cover property (sclk_pin && serial_data_out_oe);
endmodule
bind rss_serial_slave rss_serial_checker chk_u(.clk_sys(clk_sys), .sys_rst(sys_rst),
	.sel_pin(sel_pin), .sclk_pin(sclk_pin), .serial_data_out_line(serial_data_out_line),
	.serial_data_out_oe(serial_data_out_oe), .xfer_busy(xfer_busy), .wr_overflow(wr_overflow));
`default_nettype wire

// ==== tb/rss_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module rss_host_model (
	input wire logic clk_sys,
	input wire logic miso,
	output logic sel_pin,
	output logic sclk_pin,
	output logic mosi
);
	initial begin
		sel_pin = 1'b0;
		sclk_pin = 1'b0;
		mosi = 1'b0;
	end
	task automatic hold(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	// Half period of 4 system cycles gives the 200 ns serial clock
	task automatic xbyte(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
		for (int i = 7; i > 7 - nbits; i--) begin
			mosi = tx[i];
			hold(4);
			rx = {rx[6:0], miso};
			sclk_pin = 1'b1;
			hold(4);
			sclk_pin = 1'b0;
		end
	endtask
	task automatic start(input logic [7:0] cmd);
		logic [7:0] rx;
		sel_pin = 1'b1;
		hold(4);
		xbyte(cmd, 8, rx);
	endtask
	task automatic stop();
		hold(4);
		sel_pin = 1'b0;
		mosi = ~mosi;
		hold(200);
	endtask
endmodule
`default_nettype wire

// ==== tb/rss_serial_slave_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module rss_serial_slave_tb_top;
	import rss_pkg::*;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic sel_pin, sclk_pin, mosi, dout, dout_oe, miso, busy, ovf;
	logic upd_valid = 1'b0;
	logic [ADDR_W-1:0] upd_addr = 7'h00;
	logic [DATA_W-1:0] upd_data = 8'h00;
	logic [ADDR_W-1:0] live_rd_addr = 7'h00;
	logic [DATA_W-1:0] live_rd_data, rx;
	int num_errors = 0;
	int checks_done = 0;
	int cycles = 0;
	always #12.5 clk_sys = ~clk_sys;
	// Released output shows the inverse of the data line, which is cleared low with the enable, so it reads high
	assign miso = dout_oe ? dout : ~dout;
	rss_host_model host_u(.clk_sys(clk_sys), .miso(miso), .sel_pin(sel_pin),
		.sclk_pin(sclk_pin), .mosi(mosi));
	rss_serial_slave dut_u(.clk_sys(clk_sys), .sys_rst(sys_rst), .sel_pin(sel_pin),
		.sclk_pin(sclk_pin), .serial_data_in_line(mosi), .serial_data_out_line(dout),
		.serial_data_out_oe(dout_oe), .upd_valid(upd_valid), .upd_addr(upd_addr),
		.upd_data(upd_data), .live_rd_addr(live_rd_addr), .live_rd_data(live_rd_data),
		.xfer_busy(busy), .wr_overflow(ovf));
	task automatic results();
		$display("checks_done=%0d num_errors=%0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			results();
		end
	end
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic peek(input logic [6:0] a, input logic [7:0] exp);
		@(negedge clk_sys);
		live_rd_addr = a;
		repeat (2) @(negedge clk_sys);
		check(live_rd_data, exp);
	endtask
	// ==========================================
	// Scenarios
	task automatic t_reset();
		check({6'h00, busy, dout_oe}, 8'h00);
		peek(SECONDS_COUNT_ADDR, LIVE_RESET_VALUE);
	endtask
	task automatic t_write();
		host_u.start({1'b0, SECONDS_COUNT_ADDR});
		host_u.xbyte(8'h45, 8, rx);
		host_u.xbyte(8'h10, 8, rx);
		host_u.stop();
		peek(SECONDS_COUNT_ADDR, 8'h45);
		peek(MINUTES_COUNT_ADDR, 8'h10);
	endtask
	task automatic t_read();
		host_u.start({CMD_READ, SECONDS_COUNT_ADDR});
		@(negedge clk_sys);
		upd_valid = 1'b1;
		upd_addr = SECONDS_COUNT_ADDR;
		upd_data = 8'h33;
		@(negedge clk_sys);
		upd_valid = 1'b0;
		host_u.xbyte(8'h5a, 8, rx);
		check(rx, 8'h45);
		host_u.xbyte(8'ha5, 8, rx);
		check(rx, 8'h10);
		host_u.stop();
		peek(SECONDS_COUNT_ADDR, 8'h33);
	endtask
	task automatic t_wrap();
		host_u.start(8'h0f);
		host_u.xbyte(8'hc1, 8, rx);
		host_u.xbyte(8'hc2, 8, rx);
		host_u.stop();
		peek(7'h0f, 8'hc1);
		peek(7'h08, 8'hc2);
	endtask
	task automatic t_top_page();
		host_u.start(8'h7a);
		host_u.xbyte(8'h3c, 8, rx);
		host_u.stop();
		peek(7'h7a, 8'h3c);
	endtask
	task automatic t_partial();
		host_u.start(8'h10);
		host_u.xbyte(8'h77, 8, rx);
		host_u.xbyte(8'hee, 4, rx);
		host_u.stop();
		check({7'h00, dout_oe}, 8'h00);
		peek(7'h10, 8'h77);
		peek(7'h11, 8'h00);
	endtask
	initial begin
		repeat (20) @(negedge clk_sys);
		sys_rst = 1'b0;
		repeat (4) @(negedge clk_sys);
		t_reset();
		t_write();
		t_read();
		t_wrap();
		t_top_page();
		t_partial();
		results();
	end
endmodule
`default_nettype wire
